// ### rtl/ihp_host.sv
`timescale 1ns/10ps
`include "ihp_host_cfg.svh"

module ihp_host
    import ihp_host_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire ihp_req_s REQ,
    input wire logic DRIVE_RESET_REQ,
    output logic RSP_VALID,
    output logic [`IHP_DATA_W-1:0] RSP_DATA,
    output logic RSP_WORD,
    output logic IRQ_PENDING,
    output logic PASS_DIAG_SEEN,
    output logic DRIVE_ACTIVE_SEEN,
    output logic [`IHP_ADDR_W-1:0] A,
    output logic [`IHP_UPPER_W-1:0] A_UPPER,
    output logic CS0_N,
    output logic CS1_N,
    output logic IOR_N,
    output logic IOW_N,
    output logic DRV_RESET_N,
    input wire logic [`IHP_DATA_W-1:0] D_IN,
    output logic [`IHP_DATA_W-1:0] D_OUT,
    output logic [`IHP_DATA_W-1:0] D_OE_N,
    input wire logic IRQ,
    input wire logic IOIS16_N,
    input wire logic IORDY,
    input wire logic PDIAG_N_IN,
    output logic PDIAG_N_OUT,
    output logic PDIAG_N_OE_N,
    input wire logic DASP_N_IN,
    output logic DASP_N_OUT,
    output logic DASP_N_OE_N
);

    ihp_state_e state_reg, state_next;
    logic [`IHP_CNT_W-1:0] cnt_reg, cnt_next;
    ihp_req_s req_reg, req_cur;
    logic [`IHP_DATA_W-1:0] d_meta_reg, d_sync_reg;
    logic [4:0] s_meta_reg, s_sync_reg;
    logic cnt_done, word_cycle, iordy_s, iois16_n_s;

    // ==========================================================
    // input synchronisers: irq, iois16, iordy, pdiag, dasp and the data bus
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_meta_reg <= `IHP_SYNC_IDLE;
            s_sync_reg <= `IHP_SYNC_IDLE;
            d_meta_reg <= 16'h0000;
            d_sync_reg <= 16'h0000;
        end
        else
        begin
            s_meta_reg <= {DASP_N_IN, PDIAG_N_IN, IORDY, IOIS16_N, IRQ};
            s_sync_reg <= s_meta_reg;
            d_meta_reg <= D_IN;
            d_sync_reg <= d_meta_reg;
        end
    end

    assign iois16_n_s = s_sync_reg[1];
    assign iordy_s = s_sync_reg[2];

    // ==========================================================
    // status seen from the drive
    assign IRQ_PENDING = s_sync_reg[0]; // drive masks it itself
    assign PASS_DIAG_SEEN = ~s_sync_reg[3];
    assign DRIVE_ACTIVE_SEEN = ~s_sync_reg[4];

    // host only observes the handshake lines, never drives them
    assign PDIAG_N_OUT = 1'b1;
    assign PDIAG_N_OE_N = 1'b1;
    assign DASP_N_OUT = 1'b1;
    assign DASP_N_OE_N = 1'b1;
    assign A_UPPER = `IHP_UPPER_ZERO;

    // ==========================================================
    // pins follow the request from its taking edge, so stale selects never show and setup is full
    assign req_cur = (state_reg == IHP_IDLE) ? REQ : req_reg;
    // sixteen-bit cycle is the data register on the task-file select
    assign word_cycle = !req_cur.ctl_sel && (req_cur.addr == `IHP_DATA_REG_ADDR);
    assign cnt_done = (cnt_reg == 12'h000);
    assign REQ_READY = (state_reg == IHP_IDLE) && !DRIVE_RESET_REQ;

    // sequencer next state and interval counter
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_reg - 12'h001;
        case (state_reg)
            IHP_IDLE:
            begin
                if (DRIVE_RESET_REQ)
                begin
                    state_next = IHP_RESET;
                    cnt_next = 12'(`IHP_RESET_CYC - 1);
                end
                else if (REQ_VALID)
                begin
                    state_next = IHP_SETUP;
                    cnt_next = 12'(`IHP_SETUP_CYC - 1);
                end
            end
            IHP_RESET, IHP_HOLD:
            begin
                if (cnt_done)
                begin
                    state_next = IHP_IDLE;
                end
            end
            IHP_SETUP:
            begin
                if (cnt_done)
                begin
                    state_next = IHP_STROBE;
                    cnt_next = 12'(`IHP_STROBE_CYC - 1);
                end
            end
            IHP_STROBE:
            begin
                // a drive holding its ready low stretches the strobe
                if (cnt_done && iordy_s)
                begin
                    state_next = IHP_HOLD;
                    cnt_next = 12'(`IHP_HOLD_CYC - 1);
                end
            end
            default:
            begin
                state_next = IHP_IDLE;
                cnt_next = 12'h000;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= IHP_IDLE;
            cnt_reg <= 12'h000;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // request capture
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            req_reg <= '0;
        else if (state_reg == IHP_IDLE && REQ_VALID && REQ_READY)
            req_reg <= REQ;
    end

    // ==========================================================
    // pin drive, registered from the next state
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            A <= 3'h0;
            CS0_N <= 1'b1;
            CS1_N <= 1'b1;
            IOR_N <= 1'b1;
            IOW_N <= 1'b1;
            DRV_RESET_N <= 1'b1;
            D_OUT <= 16'h0000;
            D_OE_N <= `IHP_OE_ALL_OFF;
        end
        else
        begin
            DRV_RESET_N <= (state_next != IHP_RESET);
            IOR_N <= !(state_next == IHP_STROBE && !req_reg.write);
            IOW_N <= !(state_next == IHP_STROBE && req_reg.write); // rise latches the data
            if (state_next == IHP_SETUP || state_next == IHP_STROBE || state_next == IHP_HOLD)
            begin
                A <= req_cur.addr;
                CS0_N <= req_cur.ctl_sel;
                CS1_N <= !req_cur.ctl_sel;
                if (req_cur.write)
                begin
                    D_OUT <= word_cycle ? req_cur.wdata : {`IHP_BYTE_ZERO, req_cur.wdata[7:0]};
                    D_OE_N <= word_cycle ? `IHP_OE_ALL_ON : `IHP_OE_LOW_ON;
                end
                else
                    D_OE_N <= `IHP_OE_ALL_OFF;
            end
            else
            begin
                CS0_N <= 1'b1;
                CS1_N <= 1'b1;
                D_OE_N <= `IHP_OE_ALL_OFF;
            end
        end
    end

    // ==========================================================
    // answer: read data sampled in the last strobe cycle
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= 16'h0000;
            RSP_WORD <= 1'b0;
        end
        else
        begin
            RSP_VALID <= (state_reg == IHP_STROBE) && (state_next == IHP_HOLD);
            if (state_reg == IHP_STROBE && state_next == IHP_HOLD)
            begin
                RSP_WORD <= !iois16_n_s;
                if (!req_reg.write)
                    RSP_DATA <= word_cycle ? d_sync_reg : {`IHP_BYTE_ZERO, d_sync_reg[7:0]};
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_upper_low;
        A_UPPER == `IHP_UPPER_ZERO;
    endproperty
    a_upper_low: assert property (p_upper_low) else $error("upper address not low");
    property p_cs_exclusive;
        CS0_N || CS1_N;
    endproperty
    a_cs_exclusive: assert property (p_cs_exclusive) else $error("both selects low");
    property p_cs0_task;
        (!IOR_N || !IOW_N) && !req_reg.ctl_sel |-> !CS0_N && CS1_N;
    endproperty
    a_cs0_task: assert property (p_cs0_task) else $error("task access without first select");
    property p_cs1_ctl;
        (!IOR_N || !IOW_N) && req_reg.ctl_sel |-> CS0_N && !CS1_N;
    endproperty
    a_cs1_ctl: assert property (p_cs1_ctl) else $error("control access without second select");
    property p_read_width;
        $fell(IOR_N) |-> (!IOR_N)[*8] ##0 (!CS0_N || !CS1_N);
    endproperty
    a_read_width: assert property (p_read_width) else $error("read strobe too short");
    property p_read_released;
        !IOR_N |-> D_OE_N == `IHP_OE_ALL_OFF;
    endproperty
    a_read_released: assert property (p_read_released) else $error("host drives bus on read");
    property p_write_hold;
        $rose(IOW_N) |-> (D_OE_N[7:0] == 8'h00) ##1 (D_OE_N[7:0] == 8'h00 && $stable(D_OUT));
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write data not held");
    property p_byte_write;
        !IOW_N && !word_cycle |-> D_OE_N[15:8] == 8'hff;
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("upper lanes driven on byte write");
    property p_reset_pulse;
        $fell(DRV_RESET_N) |-> (!DRV_RESET_N)[*8] ##1 IOR_N && IOW_N;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("drive reset too short");
    property p_pdiag_free;
        PDIAG_N_OE_N && (PASS_DIAG_SEEN == !$past(PDIAG_N_IN, 2));
    endproperty
    a_pdiag_free: assert property (p_pdiag_free) else $error("pass diag mishandled");
    property p_dasp_free;
        DASP_N_OE_N && (DRIVE_ACTIVE_SEEN == !$past(DASP_N_IN, 2));
    endproperty
    a_dasp_free: assert property (p_dasp_free) else $error("disk active mishandled");

endmodule

// ### rtl/ihp_host_cfg.svh
`ifndef IHP_HOST_CFG_SVH
`define IHP_HOST_CFG_SVH

// ==========================================================
// clock and bus widths
`define IHP_CLK_NS 10
`define IHP_ADDR_W 3
`define IHP_UPPER_W 8
`define IHP_DATA_W 16
`define IHP_BYTE_W 8
`define IHP_CNT_W 12

// ==========================================================
// register selection
`define IHP_DATA_REG_ADDR 3'h0
`define IHP_UPPER_ZERO 8'h00
`define IHP_BYTE_ZERO 8'h00
`define IHP_OE_ALL_OFF 16'hffff
`define IHP_OE_ALL_ON 16'h0000
`define IHP_OE_LOW_ON 16'hff00
// synchroniser reset: handshake lines, ready and word line idle high, interrupt low
`define IHP_SYNC_IDLE 5'h1e

// ==========================================================
// cycle timing, least times rounded up
`define IHP_T_ADDR_SETUP_NS 70
`define IHP_T_STROBE_NS 165
`define IHP_T_HOLD_NS 30
`define IHP_T_RESET_NS 25000
`define IHP_SETUP_CYC ((`IHP_T_ADDR_SETUP_NS + `IHP_CLK_NS - 1) / `IHP_CLK_NS)
`define IHP_STROBE_CYC ((`IHP_T_STROBE_NS + `IHP_CLK_NS - 1) / `IHP_CLK_NS)
`define IHP_HOLD_CYC ((`IHP_T_HOLD_NS + `IHP_CLK_NS - 1) / `IHP_CLK_NS)
`define IHP_RESET_CYC ((`IHP_T_RESET_NS + `IHP_CLK_NS - 1) / `IHP_CLK_NS)

`endif

// ### rtl/ihp_host_pkg.sv
`include "ihp_host_cfg.svh"

package ihp_host_pkg;

    // ==========================================================
    // user request carried into the pin sequencer
    typedef struct packed {
        logic write;
        logic ctl_sel;
        logic [`IHP_ADDR_W-1:0] addr;
        logic [`IHP_DATA_W-1:0] wdata;
    } ihp_req_s;

    // ==========================================================
    // pin cycle sequencer states
    typedef enum logic [2:0] {
        IHP_IDLE,
        IHP_RESET,
        IHP_SETUP,
        IHP_STROBE,
        IHP_HOLD
    } ihp_state_e;

endpackage

// ### tb/ihp_drive_model.sv
`timescale 1ns/10ps

// ==========================================================
// drive model: task file, control register, interrupt, handshake
module ihp_drive_model
(
    input wire logic clk,
    input wire logic [2:0] a,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic rst_n,
    input wire logic [15:0] d_out,
    input wire logic [15:0] d_oe_n,
    input wire logic irq_req,
    input wire logic slow,
    input wire logic diag_ok,
    input wire logic present,
    output logic [15:0] d_in,
    output logic irq,
    output logic iois16_n,
    output logic iordy,
    output logic pdiag_n,
    output logic dasp_n
);
    logic [15:0] regs [0:7];
    logic [15:0] rdata;
    logic [7:0] devctl = 8'h00;
    logic [4:0] wcnt = 5'h00;
    logic pend = 1'b0;
    logic iow_q = 1'b1;
    logic ior_q = 1'b1;
    logic flt = 1'b0;

    // read data by select and address
    always_comb
    begin
        if (!cs1_n || a == 3'h7)
            rdata = 16'h0050;
        else
            rdata = (a == 3'h0) ? regs[0] : {8'h00, regs[a][7:0]};
    end

    // bus level: host bits, else read data, else a toggling float
    assign d_in = (~d_oe_n & d_out) | (d_oe_n & ((!ior_n && !(cs0_n && cs1_n)) ? rdata : {16{flt}}));
    assign irq = pend && !devctl[1];
    assign iois16_n = !(!cs0_n && cs1_n && a == 3'h0);
    assign iordy = !(slow && !(ior_n && iow_n) && wcnt < 5'h14); // slow drive holds ready past the strobe time
    assign pdiag_n = !diag_ok;
    assign dasp_n = !present;

    // writes on the rising write strobe, resets and interrupt state
    always @(posedge clk)
    begin
        iow_q <= iow_n;
        ior_q <= ior_n;
        flt <= !flt;
        wcnt <= (ior_n && iow_n) ? 5'h00 : wcnt + {4'h0, wcnt != 5'h1f};
        if (!rst_n)
            devctl <= 8'h00;
        else if (iow_n && !iow_q && !cs1_n && a == 3'h6)
            devctl <= d_in[7:0];
        if (!rst_n || devctl[2])
        begin
            regs <= '{default: 16'h0000};
            pend <= 1'b0;
        end
        else
        begin
            if (iow_n && !iow_q && !cs0_n)
                regs[a] <= d_in;
            if (irq_req)
                pend <= 1'b1;
            else if (ior_n && !ior_q && !cs0_n && a == 3'h7)
                pend <= 1'b0;
        end
    end
endmodule

// ### tb/ide_target_host_port_test.sv
`timescale 1ns/10ps
`include "ihp_host_cfg.svh"

// ==========================================================
// bench for the host port against the drive model
module ide_target_host_port_test
    import ihp_host_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic drv_rst_req = 1'b0;
    logic irq_req = 1'b0;
    logic slow = 1'b0;
    logic diag_ok = 1'b0;
    logic present = 1'b0;
    ihp_req_s req = '0;
    logic req_ready, rsp_valid, rsp_word, irq_pending, pass_seen, active_seen, cs0_n, cs1_n, ior_n, iow_n;
    logic drv_reset_n, irq, iois16_n, iordy, pdiag_out, pdiag_oe_n, dasp_out, dasp_oe_n, pdiag_n, dasp_n;
    logic [15:0] rsp_data, d_in, d_out, d_oe_n;
    logic [2:0] a;
    logic [7:0] a_upper;
    int fails = 0;
    int compares = 0;
    int strobe_len = 0;

    // clock and wired-and handshake lines
    always #5 clk = !clk;
    wire pdiag_in = (pdiag_oe_n | pdiag_out) & pdiag_n;
    wire dasp_in = (dasp_oe_n | dasp_out) & dasp_n;

    ihp_host DUT (.CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
        .DRIVE_RESET_REQ(drv_rst_req), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_WORD(rsp_word),
        .IRQ_PENDING(irq_pending), .PASS_DIAG_SEEN(pass_seen), .DRIVE_ACTIVE_SEEN(active_seen), .A(a),
        .A_UPPER(a_upper), .CS0_N(cs0_n), .CS1_N(cs1_n), .IOR_N(ior_n), .IOW_N(iow_n), .DRV_RESET_N(drv_reset_n),
        .D_IN(d_in), .D_OUT(d_out), .D_OE_N(d_oe_n), .IRQ(irq), .IOIS16_N(iois16_n), .IORDY(iordy),
        .PDIAG_N_IN(pdiag_in), .PDIAG_N_OUT(pdiag_out), .PDIAG_N_OE_N(pdiag_oe_n), .DASP_N_IN(dasp_in),
        .DASP_N_OUT(dasp_out), .DASP_N_OE_N(dasp_oe_n));

    ihp_drive_model drive (.clk(clk), .a(a), .cs0_n(cs0_n), .cs1_n(cs1_n), .ior_n(ior_n), .iow_n(iow_n),
        .rst_n(drv_reset_n), .d_out(d_out), .d_oe_n(d_oe_n), .irq_req(irq_req), .slow(slow), .diag_ok(diag_ok),
        .present(present), .d_in(d_in), .irq(irq), .iois16_n(iois16_n), .iordy(iordy), .pdiag_n(pdiag_n),
        .dasp_n(dasp_n));

    // ==========================================================
    // compare, verdict and bus cycle tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic access(input logic wr, input logic ctl, input logic [2:0] ad, input logic [15:0] wd,
                          output logic [15:0] rd, output logic wrd);
        int n;
        logic seen;
        req = '{write: wr, ctl_sel: ctl, addr: ad, wdata: wd};
        req_valid = 1'b1;
        for (n = 0; !req_ready; n++)
        begin
            if (n > 5000)
                fails++;
            if (n > 5000)
                final_report();
            @(negedge clk);
        end
        @(negedge clk);
        req_valid = 1'b0;
        seen = 1'b0;
        strobe_len = 0;
        for (n = 0; !rsp_valid; n++)
        begin
            if (!(ior_n && iow_n))
                strobe_len++;
            if (!seen && !(ior_n && iow_n))
            begin
                seen = 1'b1;
                check("addr", {5'h00, a, a_upper}, {5'h00, ad, 8'h00});
                check("select", {12'h000, cs0_n, cs1_n, ior_n, iow_n}, {12'h000, ctl, !ctl, wr, !wr});
                if (wr)
                    check("drive enable", d_oe_n, (!ctl && ad == 3'h0) ? 16'h0000 : 16'hff00);
            end
            if (n > 500)
                fails++;
            if (n > 500)
                final_report();
            @(negedge clk);
        end
        rd = rsp_data;
        wrd = rsp_word;
        if (!slow)
            check("strobe width", 16'(strobe_len), 16'(`IHP_STROBE_CYC));
        @(negedge clk);
    endtask

    task automatic pulse_irq();
        irq_req = 1'b1;
        @(negedge clk);
        irq_req = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        logic [15:0] rd;
        logic wrd;
        logic [15:0] wd [0:6];
        int n;
        void'($urandom(32'h418d1a40));
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        check("idle pins", {iow_n, ior_n, drv_reset_n, cs0_n, cs1_n, 3'h0, a_upper}, 16'hf800);
        access(1'b1, 1'b0, 3'h1, 16'h005a, rd, wrd);
        // hold the reset request until the sequencer is back in idle and takes it
        drv_rst_req = 1'b1;
        for (n = 0; drv_reset_n && n < 100; n++)
            @(negedge clk);
        drv_rst_req = 1'b0;
        if (n >= 100)
            fails++;
        if (n >= 100)
            final_report();
        for (n = 0; !drv_reset_n && n < 3000; n++)
            @(negedge clk);
        if (n >= 3000)
            fails++;
        if (n >= 3000)
            final_report();
        check("reset pulse", 16'(n), 16'(`IHP_RESET_CYC));
        access(1'b0, 1'b0, 3'h1, 16'h0000, rd, wrd);
        check("reset clears", rd, 16'h0000);
        for (int r = 0; r < 3; r++)
        begin
            for (int i = 0; i < 7; i++)
            begin
                wd[i] = (r == 0) ? 16'hff00 : 16'($urandom);
                access(1'b1, 1'b0, 3'(i), wd[i], rd, wrd);
            end
            for (int i = 0; i < 7; i++)
            begin
                access(1'b0, 1'b0, 3'(i), 16'h0000, rd, wrd);
                check("read data", rd, (i == 0) ? wd[i] : {8'h00, wd[i][7:0]});
                check("word cycle", {15'h0000, wrd}, {15'h0000, i == 0});
            end
        end
        pulse_irq();
        check("irq raised", {15'h0000, irq_pending}, 16'h0001);
        access(1'b0, 1'b1, 3'h6, 16'h0000, rd, wrd);
        check("alt status", rd, 16'h0050);
        repeat (4) @(negedge clk);
        check("irq kept", {15'h0000, irq_pending}, 16'h0001);
        access(1'b0, 1'b0, 3'h7, 16'h0000, rd, wrd);
        repeat (4) @(negedge clk);
        check("irq cleared", {15'h0000, irq_pending}, 16'h0000);
        access(1'b1, 1'b1, 3'h6, 16'h0002, rd, wrd);
        pulse_irq();
        check("irq masked", {15'h0000, irq_pending}, 16'h0000);
        access(1'b1, 1'b1, 3'h6, 16'h0004, rd, wrd);
        access(1'b1, 1'b0, 3'h3, 16'h00a5, rd, wrd);
        access(1'b0, 1'b0, 3'h3, 16'h0000, rd, wrd);
        check("soft reset hold", rd, 16'h0000);
        access(1'b1, 1'b1, 3'h6, 16'h0000, rd, wrd);
        access(1'b1, 1'b0, 3'h3, 16'h00a5, rd, wrd);
        slow = 1'b1;
        access(1'b0, 1'b0, 3'h3, 16'h0000, rd, wrd);
        slow = 1'b0;
        check("soft reset left", rd, 16'h00a5);
        check("strobe stretch", {15'h0000, strobe_len > `IHP_STROBE_CYC}, 16'h0001);
        diag_ok = 1'b1;
        present = 1'b1;
        repeat (4) @(negedge clk);
        check("handshake", {12'h000, pass_seen, active_seen, pdiag_oe_n, dasp_oe_n}, 16'h000f);
        final_report();
    end

    // watchdog against a hung cycle
    initial
    begin
        #1000000;
        fails++;
        final_report();
    end
endmodule
